// file: inc/edl_pkg.sv
// Layout constants and carrier types for the descriptor layout loader
package edl_pkg;
  // Programmed-indicator byte expected at address zero
  localparam logic [7:0] PROG_MARK = 8'hA5;
  // Byte addresses of the header fields
  localparam logic [4:0] HDR_MARK = 5'h00;
  localparam logic [4:0] HDR_MAC = 5'h01;
  localparam logic [4:0] HDR_FS_POLL = 5'h07;
  localparam logic [4:0] HDR_HS_POLL = 5'h08;
  localparam logic [4:0] HDR_FLAGS = 5'h09;
  localparam logic [4:0] HDR_LANG = 5'h0A;
  localparam logic [4:0] HDR_STR_MFR = 5'h0C;
  localparam logic [4:0] HDR_STR_PROD = 5'h0E;
  localparam logic [4:0] HDR_STR_SER = 5'h10;
  localparam logic [4:0] HDR_STR_CFG = 5'h12;
  localparam logic [4:0] HDR_STR_INTF = 5'h14;
  localparam logic [4:0] HDR_HS_DEV = 5'h16;
  localparam logic [4:0] HDR_HS_CFG = 5'h18;
  localparam logic [4:0] HDR_FS_DEV = 5'h1A;
  localparam logic [4:0] HDR_FS_CFG = 5'h1C;
  localparam logic [4:0] HDR_LAST = 5'h1D;
  localparam int HDR_BYTES = 30;
  // Bit positions inside the configuration flags byte
  localparam int FLAG_SELF_PWR_BIT = 1;
  localparam int FLAG_RWAKE_BIT = 2;

  typedef enum logic [2:0] {
    SEL_DEV = 3'h0,
    SEL_CFG = 3'h1,
    SEL_STR_MFR = 3'h2,
    SEL_STR_PROD = 3'h3,
    SEL_STR_SER = 3'h4,
    SEL_STR_CFG = 3'h5,
    SEL_STR_INTF = 3'h6
  } edl_sel_t;

  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_READY = 4'b0010,
    ST_DESC = 4'b0100,
    ST_FAIL = 4'b1000
  } edl_state_t;

  typedef struct packed {
    logic [47:0] mac;
    logic [7:0] fs_poll;
    logic [7:0] hs_poll;
    logic [7:0] flags;
    logic bus_powered;
    logic remote_wakeup;
    logic [15:0] lang_id;
  } edl_cfg_t;

  typedef struct packed {
    edl_sel_t sel;
    logic hs;
    logic [7:0] idx;
  } edl_req_t;
endpackage

// file: hdl/edl_loader.sv
// Descriptor layout loader: header load after reset and descriptor fetch
//
// Functional notes
// - Byte at address zero not A5h: EEPROM absent, load abandoned.
// - Bytes 01h to 06h, ascending, form the station MAC address.
// - Byte 07h is full-speed, 08h hi-speed interrupt polling interval.
// - Byte 09h holds bus-powered and remote-wakeup configuration flags.
// - Language ID from bytes 0Ah and 0Bh, lower address is low byte.
// - Manufacturer string length at 0Ch, word offset at 0Dh.
// - Product string length at 0Eh, word offset at 0Fh.
// - Serial number string length at 10h, word offset at 11h.
// - Every word offset is doubled into a byte address before fetching.
// - Configuration string length 12h, offset 13h; zero length means absent.
// - Interface string length 14h, offset 15h; zero length means absent.
// - Hi-speed device descriptor length at 16h, word offset at 17h.
// - Hi-speed configuration plus interface descriptor at 18h and 19h.
// - Full-speed device descriptor length at 1Ah, word offset at 1Bh.
// - Full-speed configuration plus interface descriptor at 1Ch and 1Dh.
// - USB transceiver stays disconnected until the load has finished.
`timescale 1ns/1ns
`default_nettype none
module edl_loader (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Byte read port toward the EEPROM command engine
  output logic ee_rd_req_o,
  output logic [8:0] ee_rd_addr_o,
  input wire logic ee_rd_ack_i,
  input wire logic [7:0] ee_rd_data_i,
  // Loaded configuration
  output edl_pkg::edl_cfg_t cfg_o,
  output logic cfg_valid_o,
  output logic load_done_o,
  output logic usb_connect_o,
  // Descriptor byte requests from the USB device core
  input wire logic desc_req_i,
  input wire edl_pkg::edl_req_t desc_i,
  output logic desc_ready_o,
  output logic desc_valid_o,
  output logic desc_err_o,
  output logic [7:0] desc_data_o,
  output logic [7:0] desc_len_o
);

  edl_pkg::edl_state_t state_ff;
  edl_pkg::edl_state_t nxt_state;
  logic [8:0] addr_ff;
  logic [8:0] nxt_addr;
  logic [7:0] hdr_ff [0:edl_pkg::HDR_BYTES-1];
  logic desc_valid_ff;
  logic desc_err_ff;
  logic [7:0] desc_data_ff;
  logic [7:0] desc_len_ff;

  // Decoded conditions
  wire in_fetch = (state_ff == edl_pkg::ST_FETCH);
  wire in_ready = (state_ff == edl_pkg::ST_READY);
  wire in_desc = (state_ff == edl_pkg::ST_DESC);
  wire in_fail = (state_ff == edl_pkg::ST_FAIL);
  wire fetch_ack = in_fetch && ee_rd_ack_i;
  wire at_mark = (addr_ff == {4'h0, edl_pkg::HDR_MARK});
  wire at_last = (addr_ff == {4'h0, edl_pkg::HDR_LAST});
  wire bad_mark = fetch_ack && at_mark && (ee_rd_data_i != edl_pkg::PROG_MARK);
  wire take_req = desc_req_i && (in_ready || in_fail);

  // Header slot of the requested descriptor; speed picks the copy
  wire [4:0] dev_base = desc_i.hs ? edl_pkg::HDR_HS_DEV : edl_pkg::HDR_FS_DEV;
  wire [4:0] cfg_base = desc_i.hs ? edl_pkg::HDR_HS_CFG : edl_pkg::HDR_FS_CFG;
  wire [4:0] sel_base =
    (desc_i.sel == edl_pkg::SEL_DEV) ? dev_base :
    (desc_i.sel == edl_pkg::SEL_CFG) ? cfg_base :
    (desc_i.sel == edl_pkg::SEL_STR_MFR) ? edl_pkg::HDR_STR_MFR :
    (desc_i.sel == edl_pkg::SEL_STR_PROD) ? edl_pkg::HDR_STR_PROD :
    (desc_i.sel == edl_pkg::SEL_STR_SER) ? edl_pkg::HDR_STR_SER :
    (desc_i.sel == edl_pkg::SEL_STR_CFG) ? edl_pkg::HDR_STR_CFG :
    edl_pkg::HDR_STR_INTF;
  wire [7:0] sel_len = hdr_ff[sel_base];
  wire [7:0] sel_off = hdr_ff[5'(sel_base + 5'h01)];
  // Zero length marks an absent descriptor, its offset is ignored
  wire sel_miss = in_fail || (sel_len == 8'h00) || (desc_i.idx >= sel_len);
  wire [8:0] sel_addr = 9'({sel_off, 1'b0} + {1'b0, desc_i.idx});

  // Header store, one slot per layout byte
  genvar gi;
  generate
    for (gi = 0; gi < edl_pkg::HDR_BYTES; gi++) begin : g_hdr
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          hdr_ff[gi] <= 8'h00;
        end else if (fetch_ack && (addr_ff == 9'(gi))) begin
          hdr_ff[gi] <= ee_rd_data_i;
        end
      end
    end
  endgenerate

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    case (state_ff)
      edl_pkg::ST_FETCH: begin
        if (bad_mark) begin
          nxt_state = edl_pkg::ST_FAIL;
        end else if (fetch_ack && at_last) begin
          nxt_state = edl_pkg::ST_READY;
        end else if (fetch_ack) begin
          nxt_addr = 9'(addr_ff + 9'h001);
        end
      end
      edl_pkg::ST_READY: begin
        if (take_req && !sel_miss) begin
          nxt_state = edl_pkg::ST_DESC;
          nxt_addr = sel_addr;
        end
      end
      edl_pkg::ST_DESC: begin
        if (ee_rd_ack_i) begin
          nxt_state = edl_pkg::ST_READY;
        end
      end
      edl_pkg::ST_FAIL: begin
        nxt_state = edl_pkg::ST_FAIL;
      end
      default: begin
        nxt_state = edl_pkg::ST_FETCH;
        nxt_addr = 9'h000;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= edl_pkg::ST_FETCH;
      addr_ff <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
    end
  end

  // Answer path: one-cycle valid, data held until the next fetched byte
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      desc_valid_ff <= 1'b0;
      desc_err_ff <= 1'b0;
      desc_data_ff <= 8'h00;
      desc_len_ff <= 8'h00;
    end else begin
      desc_valid_ff <= (take_req && sel_miss) || (in_desc && ee_rd_ack_i);
      if (take_req) begin
        desc_err_ff <= sel_miss;
        desc_len_ff <= in_fail ? 8'h00 : sel_len;
      end
      if (in_desc && ee_rd_ack_i) begin
        desc_data_ff <= ee_rd_data_i;
      end
    end
  end

  // Configuration fields straight from the header store
  genvar mi;
  generate
    for (mi = 0; mi < 6; mi++) begin : g_mac
      assign cfg_o.mac[47-8*mi -: 8] = hdr_ff[5'(edl_pkg::HDR_MAC + 5'(mi))];
    end
  endgenerate
  assign cfg_o.fs_poll = hdr_ff[edl_pkg::HDR_FS_POLL];
  assign cfg_o.hs_poll = hdr_ff[edl_pkg::HDR_HS_POLL];
  assign cfg_o.flags = hdr_ff[edl_pkg::HDR_FLAGS];
  assign cfg_o.bus_powered = !hdr_ff[edl_pkg::HDR_FLAGS][edl_pkg::FLAG_SELF_PWR_BIT];
  assign cfg_o.remote_wakeup = hdr_ff[edl_pkg::HDR_FLAGS][edl_pkg::FLAG_RWAKE_BIT];
  assign cfg_o.lang_id = {hdr_ff[5'(edl_pkg::HDR_LANG + 5'h01)], hdr_ff[edl_pkg::HDR_LANG]};

  assign ee_rd_req_o = in_fetch || in_desc;
  assign ee_rd_addr_o = addr_ff;
  assign cfg_valid_o = in_ready || in_desc;
  assign load_done_o = !in_fetch;
  assign usb_connect_o = !in_fetch;
  assign desc_ready_o = in_ready || in_fail;
  assign desc_valid_o = desc_valid_ff;
  assign desc_err_o = desc_err_ff;
  assign desc_data_o = desc_data_ff;
  assign desc_len_o = desc_len_ff;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_take_hit;
    in_ready && desc_req_i && !sel_miss;
  endsequence
  sequence s_fetch_ans;
    in_desc && ee_rd_ack_i;
  endsequence
  // Header byte arriving for one layout slot
  sequence s_hdr_byte(logic [8:0] slot);
    fetch_ack && (addr_ff == slot);
  endsequence
  sequence s_take_miss;
    take_req && sel_miss;
  endsequence

  a_mark_abandon: assert property (
    bad_mark |=> in_fail && !cfg_valid_o ##1 in_fail)
    else $error("bad programmed mark did not abandon the load");
  a_mac_order: assert property (
    fetch_ack && (addr_ff == 9'h001) |=> cfg_o.mac[47:40] == $past(ee_rd_data_i))
    else $error("first MAC byte not taken from address one");
  a_poll_fs: assert property (
    fetch_ack && (addr_ff == 9'h007) |=> cfg_o.fs_poll == $past(ee_rd_data_i))
    else $error("full-speed polling interval wrong");
  a_flags_load: assert property (
    fetch_ack && (addr_ff == 9'h009)
      |=> cfg_o.remote_wakeup == $past(ee_rd_data_i[2]))
    else $error("remote wakeup flag wrong");
  a_lang_low: assert property (
    fetch_ack && (addr_ff == 9'h00A) |=> cfg_o.lang_id[7:0] == $past(ee_rd_data_i))
    else $error("language ID low byte wrong");
  a_str_addr: assert property (
    s_take_hit ##0 (desc_i.sel == edl_pkg::SEL_STR_MFR)
      |=> ee_rd_addr_o == 9'({hdr_ff[13], 1'b0} + {1'b0, $past(desc_i.idx)}))
    else $error("manufacturer string address not doubled word offset");
  a_speed_pick: assert property (
    s_take_hit ##0 (desc_i.sel == edl_pkg::SEL_DEV)
      |=> ee_rd_addr_o == 9'({hdr_ff[$past(desc_i.hs) ? 23 : 27], 1'b0}
        + {1'b0, $past(desc_i.idx)}))
    else $error("device descriptor copy not chosen by speed");
  a_absent_str: assert property (
    in_ready && desc_req_i && (sel_len == 8'h00) |=> desc_valid_o && desc_err_o && in_ready)
    else $error("absent string not refused");
  a_desc_return: assert property (
    s_fetch_ans |=> desc_valid_o && !desc_err_o && desc_data_o == $past(ee_rd_data_i))
    else $error("fetched descriptor byte not returned");
  a_connect_late: assert property (
    $rose(usb_connect_o) |-> $past(fetch_ack && (at_last || at_mark)))
    else $error("transceiver connected before load end");

  // Header load: last MAC, hi-speed poll, power flag and language high slots land in their fields; fetch order, load end
  a_mac_last: assert property (
    s_hdr_byte(9'h006) |=> cfg_o.mac[7:0] == $past(ee_rd_data_i))
    else $error("last MAC byte not taken from address six");
  a_fetch_order: assert property (
    fetch_ack && !at_last && !bad_mark |=> addr_ff == 9'($past(addr_ff) + 9'h001))
    else $error("header fetch not in ascending order");
  a_poll_hs: assert property (
    s_hdr_byte(9'h008) |=> cfg_o.hs_poll == $past(ee_rd_data_i))
    else $error("hi-speed polling interval wrong");
  a_power_flag: assert property (
    s_hdr_byte(9'h009)
      |=> cfg_o.bus_powered == !$past(ee_rd_data_i[edl_pkg::FLAG_SELF_PWR_BIT]))
    else $error("bus powered flag wrong");
  a_lang_high: assert property (
    s_hdr_byte(9'h00B) |=> cfg_o.lang_id[15:8] == $past(ee_rd_data_i))
    else $error("language ID high byte wrong");
  a_load_end: assert property (
    fetch_ack && at_last |=> cfg_valid_o && load_done_o && usb_connect_o)
    else $error("load end not reported");
  // The host must not see the device while the header is still arriving
  a_hold_off: assert property (
    in_fetch |-> !usb_connect_o && !desc_ready_o && !load_done_o)
    else $error("transceiver released during load");

  // Abandoned load: no reads, every request refused
  a_mark_kept: assert property (
    cfg_valid_o |-> hdr_ff[edl_pkg::HDR_MARK] == edl_pkg::PROG_MARK)
    else $error("configuration valid without programmed mark");
  a_fail_quiet: assert property (
    in_fail |-> !ee_rd_req_o && !cfg_valid_o)
    else $error("abandoned load still reading");
  a_fail_refuse: assert property (
    in_fail && desc_req_i |=> desc_valid_o && desc_err_o && desc_len_o == 8'h00)
    else $error("request after abandoned load not refused");

  // Descriptor lookup: region chosen from the header pairs
  a_str_prod: assert property (
    s_take_hit ##0 (desc_i.sel == edl_pkg::SEL_STR_PROD)
      |=> ee_rd_addr_o == 9'({hdr_ff[15], 1'b0} + {1'b0, $past(desc_i.idx)}))
    else $error("product string address not doubled word offset");
  a_str_ser: assert property (
    s_take_hit ##0 (desc_i.sel == edl_pkg::SEL_STR_SER)
      |=> ee_rd_addr_o == 9'({hdr_ff[17], 1'b0} + {1'b0, $past(desc_i.idx)}))
    else $error("serial string address not doubled word offset");
  a_cfg_pick: assert property (
    s_take_hit ##0 (desc_i.sel == edl_pkg::SEL_CFG)
      |=> ee_rd_addr_o == 9'({hdr_ff[$past(desc_i.hs) ? 25 : 29], 1'b0}
        + {1'b0, $past(desc_i.idx)}))
    else $error("configuration descriptor copy not chosen by speed");
  // A refused request must not start a stray EEPROM read
  a_miss_no_read: assert property (
    s_take_miss |=> !ee_rd_req_o && desc_valid_o && desc_err_o)
    else $error("refused request started a read");
  a_len_report: assert property (
    take_req && !in_fail |=> desc_len_o == $past(sel_len))
    else $error("descriptor length not reported");
  a_req_hold: assert property (
    in_desc && !ee_rd_ack_i |=> in_desc && $stable(ee_rd_addr_o))
    else $error("descriptor read dropped before answer");
  a_busy_ready: assert property (
    in_desc |-> !desc_ready_o && ee_rd_req_o)
    else $error("new request accepted while one is outstanding");
endmodule // edl_loader
`default_nettype wire

// file: tb/edl_eeprom_model.sv
// Behavioural EEPROM read engine holding the example descriptor image
`timescale 1ns/1ns
`default_nettype none
module edl_eeprom_model (
  // Clock
  input wire logic ref_clk_i,
  // Byte read port
  input wire logic ee_rd_req_i,
  input wire logic [8:0] ee_rd_addr_i,
  input wire logic [3:0] lat_i,
  output logic ee_rd_ack_o,
  output logic [7:0] ee_rd_data_o
);
  // Strings carry size, type 03h, then low-byte-first characters
  // Vendor, product and release words and string text in the image are arbitrary
  localparam logic [767:0] IMG = {
    192'hA512_3456_789A_BC01_0404_0904_0A0F_1014_101C_0000_0000_1224,
    192'h122D_1236_123F_0A03_4500_4400_4C00_5800_1003_4C00_4F00_4100,
    192'h4400_4500_5200_3100_1003_3000_3000_3000_3500_3100_3200_3300,
    192'h1201_0002_FF00_0140_5A5A_C3C3_0A0A_0102_0301_0902_2700_0101};
  logic [7:0] mem [0:511];
  logic [3:0] wait_ff;
  initial begin
    ee_rd_ack_o = 1'b0;
    ee_rd_data_o = 8'h00;
    wait_ff = 4'h0;
    // Past the image each byte is its address low byte XOR C3h so region picks show
    for (int a = 0; a < 512; a++) begin
      mem[a] = (a < 96) ? IMG[767-8*a -: 8] : (8'(a) ^ 8'hC3);
    end
  end
  // Data is good only with ack; otherwise it toggles every cycle
  always @(posedge ref_clk_i) begin
    ee_rd_ack_o <= 1'b0;
    ee_rd_data_o <= ~ee_rd_data_o;
    if (ee_rd_req_i && !ee_rd_ack_o) begin
      if (wait_ff >= lat_i) begin
        ee_rd_ack_o <= 1'b1;
        ee_rd_data_o <= mem[ee_rd_addr_i];
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule // edl_eeprom_model
`default_nettype wire

// file: tb/edl_loader_bench.sv
// Self-checking bench for the descriptor layout loader
`timescale 1ns/1ns
`default_nettype none
module edl_loader_bench;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] lat = 4'h0;
  logic desc_req = 1'b0;
  edl_pkg::edl_req_t desc = '0;
  edl_pkg::edl_cfg_t cfg;
  logic rd_req, rd_ack, cfg_valid, load_done, connect, ready, valid, derr;
  logic [8:0] rd_addr;
  logic [7:0] rd_data, ddata, dlen;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  edl_loader i_edl_loader (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .ee_rd_req_o(rd_req), .ee_rd_addr_o(rd_addr), .ee_rd_ack_i(rd_ack),
    .ee_rd_data_i(rd_data), .cfg_o(cfg), .cfg_valid_o(cfg_valid),
    .load_done_o(load_done), .usb_connect_o(connect), .desc_req_i(desc_req),
    .desc_i(desc), .desc_ready_o(ready), .desc_valid_o(valid), .desc_err_o(derr),
    .desc_data_o(ddata), .desc_len_o(dlen));
  edl_eeprom_model i_edl_eeprom_model (.ref_clk_i(ref_clk_i), .ee_rd_req_i(rd_req),
    .ee_rd_addr_i(rd_addr), .lat_i(lat), .ee_rd_ack_o(rd_ack), .ee_rd_data_o(rd_data));

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
  endtask

  task automatic wait_load;
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (load_done !== 1'b1 && n < 500) begin
      check("connect_early", connect, 1'b0);
      @(negedge ref_clk_i);
      n++;
    end
    check("connect_done", connect, 1'b1);
  endtask

  // One descriptor byte; idx at or past len expects a refusal
  task automatic ask(input logic [2:0] sel, input logic hs, input logic [7:0] idx,
                     input logic [7:0] len, input logic [8:0] addr);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    check("desc_ready", ready, 1'b1);
    @(posedge ref_clk_i);
    desc_req <= 1'b1;
    desc <= '{edl_pkg::edl_sel_t'(sel), hs, idx};
    @(posedge ref_clk_i);
    desc_req <= 1'b0;
    n = 0;
    @(negedge ref_clk_i);
    while (valid !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    check("desc_valid", valid, 1'b1);
    check("desc_len", dlen, len);
    check("desc_err", derr, idx >= len);
    if (idx < len) check("desc_data", ddata, i_edl_eeprom_model.mem[addr]);
  endtask

  task automatic t_load;
    wait_load();
    check("cfg_valid", cfg_valid, 1'b1);
    check("mac", cfg.mac, 48'h1234_5678_9ABC);
    check("fs_poll", cfg.fs_poll, 8'h01);
    check("hs_poll", cfg.hs_poll, 8'h04);
    check("flags", {cfg.flags, cfg.bus_powered, cfg.remote_wakeup}, 10'h013);
    check("lang_id", cfg.lang_id, 16'h0409);
  endtask

  task automatic t_desc;
    @(posedge ref_clk_i);
    lat <= 4'h2;
    ask(3'h2, 1'b0, 8'h00, 8'h0A, 9'h01E);
    ask(3'h2, 1'b0, 8'h09, 8'h0A, 9'h027);
    ask(3'h2, 1'b0, 8'h0A, 8'h0A, 9'h000);
    ask(3'h3, 1'b1, 8'h01, 8'h10, 9'h029);
    ask(3'h4, 1'b0, 8'h0F, 8'h10, 9'h047);
    ask(3'h5, 1'b0, 8'h00, 8'h00, 9'h000);
    ask(3'h6, 1'b1, 8'h00, 8'h00, 9'h000);
    ask(3'h0, 1'b1, 8'h03, 8'h12, 9'h04B);
    ask(3'h1, 1'b1, 8'h11, 8'h12, 9'h06B);
    ask(3'h0, 1'b0, 8'h11, 8'h12, 9'h07D);
    ask(3'h1, 1'b0, 8'h05, 8'h12, 9'h083);
  endtask

  task automatic t_bad;
    @(posedge ref_clk_i);
    lat <= 4'h3;
    i_edl_eeprom_model.mem[0] = 8'h5A;
    do_reset();
    wait_load();
    check("bad_cfg_valid", cfg_valid, 1'b0);
    check("bad_rd_stop", {rd_req, rd_addr}, 10'h000);
    ask(3'h0, 1'b1, 8'h00, 8'h00, 9'h000);
  endtask

  initial begin
    do_reset();
    t_load();
    t_desc();
    t_bad();
    give_verdict();
  end
endmodule // edl_loader_bench
`default_nettype wire
